// ### common/hfc_pkg.sv
package hfc_pkg;

	// System clock and link timing.
	localparam int CLK_PERIOD_PS = 25000;
	localparam int CS_HIGH_NS    = 500;
	localparam int CS_HIGH_CYC   = (CS_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SPI_HALF_NS   = 100;
	localparam int SPI_HALF_CYC  = (SPI_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int I2C_BIT_NS    = 295;
	localparam int I2C_QTR_CYC   = (I2C_BIT_NS * 1000 + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS);

	// Frame geometry.
	localparam int BYTE_BITS       = 8;
	localparam int SPI_FRAME_BITS  = 32;
	localparam int I2C_FRAME_BYTES = 5;
	localparam int I2C_FRAME_BITS  = I2C_FRAME_BYTES * BYTE_BITS;
	localparam int I2C_SLOTS       = I2C_FRAME_BYTES * (BYTE_BITS + 1);
	localparam int REG_INDEX_W     = 6;
	localparam int REG_ADDR_W      = REG_INDEX_W + 1;
	localparam int REG_WORDS       = 2 ** REG_ADDR_W;
	localparam int DATA_W          = 16;
	localparam int STATUS_W        = 7;
	localparam int FUSE_W          = 4;

	// Check byte: x^8+x^4+x^3+x^2+1, seed all ones.
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_SEED = 8'hFF;

	// Per check bit, the frame bits that feed it, and the parity of its constant ones.
	localparam logic [7:0][31:0] SPI_CRC_MASK = {
		32'h81D2_3800, 32'hC0E9_1C00, 32'h6074_8E00, 32'h303A_4700,
		32'h19CF_1B00, 32'h0D35_B500, 32'h0748_E200, 32'h03A4_7100};
	localparam logic [7:0] SPI_CRC_ONES = 8'h0E;

	// Encodings.
	localparam logic [1:0] I2C_ADDR_PREFIX = 2'h1;
	localparam logic       LOGIC_MAIN      = 1'b0;
	localparam logic       LOGIC_FAILSAFE  = 1'b1;
	localparam logic       ACCESS_WRITE    = 1'b1;
	localparam logic       I2C_RW_WRITE    = 1'b0;
	localparam logic [1:0] I2C_INDEX_PAD   = 2'h0;

	typedef struct packed {
		logic                   logicDomainSelect;
		logic [REG_INDEX_W-1:0] index;
		logic                   rw;
		logic [DATA_W-1:0]      data;
		logic [7:0]             crc;
	} hfc_spi_frame_t;

	typedef struct packed {
		logic [1:0]        prefix;
		logic [FUSE_W-1:0] fuse;
		logic              logicDomainSelect;
	} hfc_i2c_addr_t;

	typedef struct packed {
		hfc_i2c_addr_t          busTargetAddressBits;
		logic                   rw;
		logic [1:0]             pad;
		logic [REG_INDEX_W-1:0] index;
		logic [DATA_W-1:0]      data;
		logic [7:0]             crc;
	} hfc_i2c_frame_t;

	function automatic logic [7:0] spiCheckByte(input logic [SPI_FRAME_BITS-1:0] f);
		logic [7:0] c;
		c = '0;
		for (int i = 0; i < BYTE_BITS; i++) begin
			c[i] = (^(f & SPI_CRC_MASK[i])) ^ SPI_CRC_ONES[i];
		end
		return c;
	endfunction : spiCheckByte

	function automatic logic [7:0] crcStepByte(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		logic       fb;
		r = c;
		for (int i = BYTE_BITS - 1; i >= 0; i--) begin
			fb = r[7] ^ b[i];
			r = {r[6:0], 1'b0};
			if (fb) begin
				r = r ^ CRC_POLY;
			end
		end
		return r;
	endfunction : crcStepByte

endpackage : hfc_pkg

// ### common/hfc_link_if.sv
`timescale 1ns/1ps
interface hfc_link_if;
	logic csN;
	logic sclk;
	logic mosi;
	logic misoOut;
	logic misoOeN;
	logic sclOut;
	logic sclOeN;
	logic hostSdaOut;
	logic hostSdaOeN;
	logic devSdaOut;
	logic devSdaOeN;
	logic misoLine;
	logic sclLine;
	logic sdaLine;

	// Pulled-up wires resolved from the drivers' enables.
	assign misoLine = misoOeN ? 1'b1 : misoOut;
	assign sclLine  = sclOeN ? 1'b1 : sclOut;
	assign sdaLine  = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);

	modport host (
		output csN, sclk, mosi, sclOut, sclOeN, hostSdaOut, hostSdaOeN,
		input  misoLine, sdaLine
	);

	modport device (
		input  csN, sclk, mosi, sclLine, sdaLine,
		output misoOut, misoOeN, devSdaOut, devSdaOeN
	);
endinterface : hfc_link_if

// ### verilog/hfc_device_end.sv
`timescale 1ns/1ps
// Functional notes
// - Check bit 7 from its frame bit set.
// - Check bit 6 from its frame bit set.
// - Check bit 5 from its frame bit set.
// - Check bit 4 from its frame bit set.
// - Check bit 3 from its frame bit set.
// - Check bit 2 from its frame bit set.
// - Check bit 1 from its frame bit set.
// - Check bit 0 from its frame bit set.
// - Serial frame: command byte, data, check byte.
// - Act as high-speed two-wire target.
// - Two target addresses, main and fail-safe.
// - Address is 01, then fuse bits.
// - Address low bit picks main or fail-safe.
// - Serial check uses polynomial 1D, seed FF.
// - Serial command word field layout.
// - Two-wire frame: address, 00+index, data, check.
// - Zero remainder over whole message means valid; the two-wire target also requires the 00 pad.
module hfc_device_end (
	// Link
	hfc_link_if.device                         link,
	// System clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	// Configuration
	input  wire logic [hfc_pkg::FUSE_W-1:0]    fuseAddr,
	input  wire logic [hfc_pkg::STATUS_W-1:0]  deviceStatus,
	// Write report
	output logic                               wrStrobe,
	output logic                               wrDomain,
	output logic [hfc_pkg::REG_INDEX_W-1:0]    wrIndex,
	output logic [hfc_pkg::DATA_W-1:0]         wrData,
	output logic                               communicationErrorFlag,
	output logic                               frameReject
);

	typedef enum logic [1:0] {I2C_IDLE, I2C_BITS, I2C_ACK, I2C_IGNORE} hfc_i2c_state_t;

	localparam int FB = hfc_pkg::SPI_FRAME_BITS;
	localparam int MB = hfc_pkg::I2C_FRAME_BITS;
	localparam int BB = hfc_pkg::BYTE_BITS;
	localparam int AW = hfc_pkg::REG_ADDR_W;

	// Link-clock domain.
	logic [5:0]    bitCntQ;
	logic [FB-1:0] rxShiftQ;
	logic [FB-1:0] frameQ;
	logic [FB-1:0] txShiftQ;
	logic [FB-1:0] txWordQ;
	logic          frameTglQ;
	logic          txStartedQ;
	logic          misoOeNQ;
	wire           frameLast = bitCntQ == 6'(FB - 1);
	wire  [FB-1:0] rxNext    = {rxShiftQ[FB-2:0], link.mosi};

	always_ff @(negedge link.sclk or posedge link.csN) begin
		if (link.csN) begin
			bitCntQ <= '0;
		end else begin
			bitCntQ <= bitCntQ + 6'h1;
		end
	end

	always_ff @(negedge link.sclk) begin
		rxShiftQ <= rxNext;
		if (!link.csN && frameLast) begin
			frameQ <= rxNext;
		end
	end

	always_ff @(negedge link.sclk or posedge reset) begin
		if (reset) begin
			frameTglQ <= 1'b0;
		end else if (!link.csN && frameLast) begin
			frameTglQ <= ~frameTglQ;
		end
	end

	always_ff @(posedge link.sclk or posedge link.csN) begin
		if (link.csN) begin
			txStartedQ <= 1'b0;
			misoOeNQ   <= 1'b1;
		end else begin
			txStartedQ <= 1'b1;
			misoOeNQ   <= 1'b0;
		end
	end

	// The response word is steady while the link is idle between frames.
	always_ff @(posedge link.sclk) begin
		txShiftQ <= txStartedQ ? (txShiftQ << 1) : txWordQ;
	end

	assign link.misoOut   = txShiftQ[FB-1];
	assign link.misoOeN   = misoOeNQ;
	assign link.devSdaOut = 1'b0;

	// System domain: frame arrival crossing.
	logic tglS1Q;
	logic tglS2Q;
	logic tglS3Q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tglS1Q <= 1'b0;
			tglS2Q <= 1'b0;
			tglS3Q <= 1'b0;
		end else begin
			tglS1Q <= frameTglQ;
			tglS2Q <= tglS1Q;
			tglS3Q <= tglS2Q;
		end
	end

	hfc_pkg::hfc_spi_frame_t spiF;
	assign spiF = frameQ;
	wire          spiNew   = tglS2Q ^ tglS3Q;
	wire  [7:0]   spiCheck = hfc_pkg::spiCheckByte(frameQ);
	wire          spiOk    = spiCheck == spiF.crc;
	wire [AW-1:0] spiAddr  = {spiF.logicDomainSelect, spiF.index};

	// System domain: two-wire target.
	logic sclS1Q;
	logic sclS2Q;
	logic sclS3Q;
	logic sdaS1Q;
	logic sdaS2Q;
	logic sdaS3Q;
	hfc_i2c_state_t i2cStQ;
	hfc_i2c_state_t i2cStD;
	logic [3:0]    bitCnQ;
	logic [3:0]    bitCnD;
	logic [2:0]    byteCnQ;
	logic [2:0]    byteCnD;
	logic [BB-1:0] shQ;
	logic [BB-1:0] shD;
	logic [MB-1:0] msgQ;
	logic [MB-1:0] msgD;
	logic [7:0]    crcQ;
	logic [7:0]    crcD;
	logic          sdaOeNQ;
	logic          sdaOeND;
	logic          i2cDoneQ;
	logic          i2cDoneD;
	logic          i2cPendQ;
	logic [AW-1:0] i2cAddrQ;
	logic [hfc_pkg::DATA_W-1:0] i2cDataQ;

	hfc_pkg::hfc_i2c_addr_t  headAddr;
	hfc_pkg::hfc_i2c_frame_t msgF;
	assign headAddr = shQ[BB-1:1];
	assign msgF     = msgQ;

	wire sclRise   = sclS2Q & ~sclS3Q;
	wire sclFall   = ~sclS2Q & sclS3Q;
	wire startCond = sclS2Q & sclS3Q & sdaS3Q & ~sdaS2Q;
	wire stopCond  = sclS2Q & sclS3Q & ~sdaS3Q & sdaS2Q;
	wire byteFull  = bitCnQ == 4'(BB);
	wire addrHit   = (headAddr.prefix == hfc_pkg::I2C_ADDR_PREFIX) && (headAddr.fuse == fuseAddr) &&
	                 (shQ[0] == hfc_pkg::I2C_RW_WRITE);
	wire ackThis   = (byteCnQ == 3'h0) ? addrHit : (byteCnQ < 3'(hfc_pkg::I2C_FRAME_BYTES));
	wire i2cOk     = (crcQ == 8'h00) && (msgF.pad == hfc_pkg::I2C_INDEX_PAD);

	always_comb begin
		i2cStD   = i2cStQ;
		bitCnD   = bitCnQ;
		byteCnD  = byteCnQ;
		shD      = shQ;
		msgD     = msgQ;
		crcD     = crcQ;
		sdaOeND  = 1'b1;
		i2cDoneD = 1'b0;
		if (startCond) begin
			i2cStD  = I2C_BITS;
			bitCnD  = '0;
			byteCnD = '0;
			crcD    = hfc_pkg::CRC_SEED;
		end else if (stopCond) begin
			i2cStD   = I2C_IDLE;
			i2cDoneD = (i2cStQ == I2C_BITS) && (byteCnQ == 3'(hfc_pkg::I2C_FRAME_BYTES));
		end else begin
			unique case (i2cStQ)
				I2C_IDLE, I2C_IGNORE: begin
				end
				I2C_BITS: begin
					if (sclRise && !byteFull) begin
						shD    = {shQ[BB-2:0], sdaS2Q};
						bitCnD = bitCnQ + 4'h1;
					end else if (sclFall && byteFull) begin
						if (ackThis) begin
							i2cStD  = I2C_ACK;
							sdaOeND = 1'b0;
							msgD    = {msgQ[MB-BB-1:0], shQ};
							crcD    = hfc_pkg::crcStepByte(crcQ, shQ);
						end else begin
							i2cStD = I2C_IGNORE;
						end
					end
				end
				I2C_ACK: begin
					sdaOeND = 1'b0;
					if (sclFall) begin
						sdaOeND = 1'b1;
						i2cStD  = I2C_BITS;
						bitCnD  = '0;
						byteCnD = byteCnQ + 3'h1;
					end
				end
			endcase
		end
	end

	// Sampled every system clock, fast enough for the high-speed bit rate.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{sclS1Q, sclS2Q, sclS3Q, sdaS1Q, sdaS2Q, sdaS3Q} <= '1;
			i2cStQ   <= I2C_IDLE;
			bitCnQ   <= '0;
			byteCnQ  <= '0;
			shQ      <= '0;
			msgQ     <= '0;
			crcQ     <= hfc_pkg::CRC_SEED;
			sdaOeNQ  <= 1'b1;
			i2cDoneQ <= 1'b0;
		end else begin
			{sclS1Q, sclS2Q, sclS3Q} <= {link.sclLine, sclS1Q, sclS2Q};
			{sdaS1Q, sdaS2Q, sdaS3Q} <= {link.sdaLine, sdaS1Q, sdaS2Q};
			i2cStQ   <= i2cStD;
			bitCnQ   <= bitCnD;
			byteCnQ  <= byteCnD;
			shQ      <= shD;
			msgQ     <= msgD;
			crcQ     <= crcD;
			sdaOeNQ  <= sdaOeND;
			i2cDoneQ <= i2cDoneD;
		end
	end

	assign link.devSdaOeN = sdaOeNQ;

	// Register store, shared by both transports; serial frames take precedence.
	logic [hfc_pkg::DATA_W-1:0] regMemQ [0:hfc_pkg::REG_WORDS-1];
	logic                       commErrQ;

	wire i2cGood  = i2cDoneQ & i2cOk;
	wire i2cBad   = i2cDoneQ & ~i2cOk;
	wire spiWr    = spiNew & spiOk & (spiF.rw == hfc_pkg::ACCESS_WRITE);
	wire i2cWr    = i2cPendQ & ~spiNew;
	wire wrEn     = spiWr | i2cWr;
	wire rejectEv = (spiNew & ~spiOk) | i2cBad;
	wire goodEv   = (spiNew & spiOk) | i2cGood;
	wire commErrD = rejectEv | (commErrQ & ~goodEv);
	wire [AW-1:0]                wrAddr = spiNew ? spiAddr : i2cAddrQ;
	wire [hfc_pkg::DATA_W-1:0]   wrVal  = spiNew ? spiF.data : i2cDataQ;
	wire [FB-BB-1:0]             respHi = {commErrD, deviceStatus, regMemQ[spiAddr]};
	wire [FB-1:0]                respLo = {respHi, {BB{1'b0}}};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < hfc_pkg::REG_WORDS; i++) begin
				regMemQ[i] <= '0;
			end
		end else if (wrEn) begin
			regMemQ[wrAddr] <= wrVal;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			i2cPendQ <= 1'b0;
			i2cAddrQ <= '0;
			i2cDataQ <= '0;
			txWordQ  <= '0;
			commErrQ <= 1'b0;
		end else begin
			i2cPendQ <= i2cGood | (i2cPendQ & ~i2cWr);
			if (i2cGood) begin
				i2cAddrQ <= {msgF.busTargetAddressBits.logicDomainSelect, msgF.index};
				i2cDataQ <= msgF.data;
			end
			if (spiNew) begin
				txWordQ <= {respHi, hfc_pkg::spiCheckByte(respLo)};
			end
			commErrQ <= commErrD;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrStrobe               <= 1'b0;
			{wrDomain, wrIndex}    <= '0;
			wrData                 <= '0;
			communicationErrorFlag <= 1'b0;
			frameReject            <= 1'b0;
		end else begin
			wrStrobe               <= wrEn;
			{wrDomain, wrIndex}    <= wrAddr;
			wrData                 <= wrVal;
			communicationErrorFlag <= commErrD;
			frameReject            <= rejectEv;
		end
	end

endmodule : hfc_device_end

// ### verilog/hfc_host_end.sv
`timescale 1ns/1ps
module hfc_host_end #(
	parameter int SPI_HALF = hfc_pkg::SPI_HALF_CYC,
	parameter int I2C_QTR  = hfc_pkg::I2C_QTR_CYC,
	parameter int CS_GAP   = hfc_pkg::CS_HIGH_CYC
) (
	// Link
	hfc_link_if.host                           link,
	// System clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	// Serial request
	input  wire logic                          spiReq,
	input  wire logic                          spiDomain,
	input  wire logic [hfc_pkg::REG_INDEX_W-1:0] spiIndex,
	input  wire logic                          spiWrite,
	input  wire logic [hfc_pkg::DATA_W-1:0]    spiData,
	// Two-wire request
	input  wire logic                          i2cReq,
	input  wire logic [hfc_pkg::FUSE_W-1:0]    i2cFuse,
	input  wire logic                          i2cDomain,
	input  wire logic [hfc_pkg::REG_INDEX_W-1:0] i2cIndex,
	input  wire logic [hfc_pkg::DATA_W-1:0]    i2cData,
	// Answers
	output logic                               busy,
	output logic                               spiDone,
	output logic [hfc_pkg::SPI_FRAME_BITS-1:0] spiResp,
	output logic                               spiRespOk,
	output logic                               i2cDone,
	output logic                               i2cNack
);

	typedef enum logic [2:0] {H_IDLE, H_SPI, H_I2C_START, H_I2C_BITS, H_I2C_STOP, H_GAP} hfc_host_state_t;

	localparam int FB = hfc_pkg::SPI_FRAME_BITS;
	localparam int BB = hfc_pkg::BYTE_BITS;
	localparam int NS = hfc_pkg::I2C_SLOTS;

	hfc_host_state_t stQ;
	logic [7:0]    tickQ;
	logic [5:0]    bitQ;
	logic [1:0]    phQ;
	logic [3:0]    slotBitQ;
	logic [FB-1:0] txQ;
	logic [FB-1:0] rxQ;
	logic [NS-1:0] patQ;
	logic          csNQ;
	logic          sclkQ;
	logic          mosiQ;
	logic          sclOeNQ;
	logic          sdaOeNQ;
	logic          misoS1Q;
	logic          misoS2Q;
	logic          sdaS1Q;
	logic          sdaS2Q;

	hfc_pkg::hfc_spi_frame_t spiF;
	hfc_pkg::hfc_spi_frame_t rxF;
	hfc_pkg::hfc_i2c_addr_t  i2cAddr;
	assign spiF.logicDomainSelect = spiDomain;
	assign spiF.index             = spiIndex;
	assign spiF.rw                = spiWrite;
	assign spiF.data              = spiData;
	assign spiF.crc               = hfc_pkg::spiCheckByte({spiDomain, spiIndex, spiWrite, spiData, {BB{1'b0}}});
	assign rxF                    = rxQ;
	assign i2cAddr.prefix         = hfc_pkg::I2C_ADDR_PREFIX;
	assign i2cAddr.fuse           = i2cFuse;
	assign i2cAddr.logicDomainSelect = i2cDomain;

	wire [BB-1:0] byteA = {i2cAddr, hfc_pkg::I2C_RW_WRITE};
	wire [BB-1:0] byteR = {hfc_pkg::I2C_INDEX_PAD, i2cIndex};
	wire [BB-1:0] crcA  = hfc_pkg::crcStepByte(hfc_pkg::CRC_SEED, byteA);
	wire [BB-1:0] crcR  = hfc_pkg::crcStepByte(crcA, byteR);
	wire [BB-1:0] crcH  = hfc_pkg::crcStepByte(crcR, i2cData[hfc_pkg::DATA_W-1:BB]);
	wire [BB-1:0] crcL  = hfc_pkg::crcStepByte(crcH, i2cData[BB-1:0]);
	wire [NS-1:0] i2cPat = {byteA, 1'b1, byteR, 1'b1, i2cData[hfc_pkg::DATA_W-1:BB], 1'b1,
	                        i2cData[BB-1:0], 1'b1, crcL, 1'b1};
	wire [7:0] tickLim = (stQ == H_SPI) ? 8'(SPI_HALF) : (stQ == H_GAP) ? 8'(CS_GAP) : 8'(I2C_QTR);
	wire       tick    = tickQ >= tickLim - 8'h1;
	wire       ackSlot = slotBitQ == 4'(BB);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{misoS1Q, misoS2Q, sdaS1Q, sdaS2Q} <= '1;
		end else begin
			{misoS1Q, misoS2Q} <= {link.misoLine, misoS1Q};
			{sdaS1Q, sdaS2Q}   <= {link.sdaLine, sdaS1Q};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stQ <= H_IDLE;
			{tickQ, bitQ, phQ, slotBitQ} <= '0;
			{txQ, rxQ, patQ} <= '0;
			{csNQ, sclOeNQ, sdaOeNQ} <= '1;
			{sclkQ, mosiQ, busy, spiDone, spiRespOk, i2cDone, i2cNack} <= '0;
			spiResp <= '0;
		end else begin
			spiDone <= 1'b0;
			i2cDone <= 1'b0;
			tickQ   <= (tick || stQ == H_IDLE) ? 8'h0 : tickQ + 8'h1;
			unique case (stQ)
				H_IDLE: begin
					bitQ     <= '0;
					phQ      <= '0;
					slotBitQ <= '0;
					if (spiReq) begin
						stQ  <= H_SPI;
						txQ  <= spiF;
						csNQ <= 1'b0;
					end else if (i2cReq) begin
						stQ     <= H_I2C_START;
						patQ    <= i2cPat;
						sdaOeNQ <= 1'b0;
						i2cNack <= 1'b0;
					end
				end
				H_SPI: if (tick) begin
					if (!sclkQ && bitQ == 6'(FB)) begin
						csNQ      <= 1'b1;
						stQ       <= H_GAP;
						spiDone   <= 1'b1;
						spiResp   <= rxQ;
						spiRespOk <= hfc_pkg::spiCheckByte(rxQ) == rxF.crc;
					end else if (!sclkQ) begin
						sclkQ <= 1'b1;
						mosiQ <= txQ[FB-1];
						txQ   <= txQ << 1;
					end else begin
						sclkQ <= 1'b0;
						rxQ   <= {rxQ[FB-2:0], misoS2Q};
						bitQ  <= bitQ + 6'h1;
					end
				end
				H_I2C_START: if (tick) begin
					stQ <= H_I2C_BITS;
				end
				H_I2C_BITS: if (tick) begin
					phQ <= phQ + 2'h1;
					unique case (phQ)
						2'h0: sclOeNQ <= 1'b0;
						2'h1: sdaOeNQ <= patQ[NS-1];
						2'h2: sclOeNQ <= 1'b1;
						2'h3: begin
							i2cNack  <= i2cNack | (ackSlot & sdaS2Q);
							patQ     <= patQ << 1;
							slotBitQ <= ackSlot ? 4'h0 : slotBitQ + 4'h1;
							bitQ     <= bitQ + 6'h1;
							if (bitQ == 6'(NS - 1)) begin
								stQ <= H_I2C_STOP;
							end
						end
					endcase
				end
				H_I2C_STOP: if (tick) begin
					phQ <= phQ + 2'h1;
					unique case (phQ)
						2'h0: sclOeNQ <= 1'b0;
						2'h1: sdaOeNQ <= 1'b0;
						2'h2: sclOeNQ <= 1'b1;
						2'h3: begin
							sdaOeNQ <= 1'b1;
							i2cDone <= 1'b1;
							stQ     <= H_GAP;
						end
					endcase
				end
				H_GAP: if (tick) begin
					stQ <= H_IDLE;
				end
			endcase
			busy <= !(stQ == H_IDLE && !spiReq && !i2cReq) && !(stQ == H_GAP && tick);
		end
	end

	assign link.csN        = csNQ;
	assign link.sclk       = sclkQ;
	assign link.mosi       = mosiQ;
	assign link.sclOut     = 1'b0;
	assign link.sclOeN     = sclOeNQ;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOeN = sdaOeNQ;

endmodule : hfc_host_end

// ### verification/hfc_link_chk.sv
`timescale 1ns/1ps
module hfc_link_chk #(
	parameter int CS_GAP = hfc_pkg::CS_HIGH_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Link
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic misoOeN,
	input wire logic devSdaOeN,
	input wire logic sclOeN,
	input wire logic sclLine,
	input wire logic sdaLine
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	logic sclkPrev;
	int   fallCnt;
	int   gapCnt;

	// Counts serial clock falls in a frame and the high time of the chip select.
	always_ff @(posedge clk_sys) begin
		sclkPrev <= sclk;
		fallCnt  <= (reset || csN) ? 0 : fallCnt + int'(sclkPrev && !sclk);
		gapCnt   <= reset ? CS_GAP : (!csN ? 0 : gapCnt + int'(gapCnt < 1000));
	end

	chk_sclk_idle: assert property (csN |-> !sclk) else $error("sclk not idle low");
	chk_miso_release: assert property (!misoOeN |-> !csN) else $error("miso driven outside frame");
	chk_frame_len: assert property ($rose(csN) |-> fallCnt == 32) else $error("frame not 32 bits");
	chk_mosi_hold: assert property (sclk && $past(sclk, 2) |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	chk_cs_gap: assert property ($fell(csN) |-> gapCnt >= CS_GAP) else $error("chip select gap short");
	chk_ack_low: assert property ($changed(devSdaOeN) |-> !sclLine) else $error("sda moved with scl high");
	chk_ack_window: assert property ($fell(devSdaOeN) |-> ##[1:20] devSdaOeN)
		else $error("ack held too long");
	chk_bus_apart: assert property (!csN |-> sclLine && sdaLine && sclOeN)
		else $error("two-wire active in serial frame");

	cover property ($rose(csN));
	cover property ($fell(sclOeN));
	cover property ($fell(devSdaOeN));
endmodule : hfc_link_chk

// ### verification/host_frame_crc_and_i2c_addressing_test.sv
`timescale 1ns/1ps
module host_frame_crc_and_i2c_addressing_test;
	localparam logic [6:0] STAT = 7'h5A;
	localparam logic [3:0] FUSE = 4'hA;
	typedef struct {logic d; logic [5:0] x; logic w; logic [15:0] v; logic [7:0] c;} hfc_row_t;
	hfc_row_t rows [6] = '{'{1'b0, 6'h02, 1'b1, 16'h0000, 8'h87}, '{1'b1, 6'h01, 1'b1, 16'hD00D, 8'h54},
		'{1'b0, 6'h02, 1'b0, 16'h0000, 8'h00}, '{1'b1, 6'h3F, 1'b1, 16'hFFFF, 8'h00},
		'{1'b1, 6'h01, 1'b1, 16'h1234, 8'h00}, '{1'b0, 6'h00, 1'b0, 16'h0000, 8'h00}};
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        spiReq = 1'b0, spiDomain = 1'b0, spiWrite = 1'b0, i2cReq = 1'b0, i2cDomain = 1'b0;
	logic [5:0]  spiIndex = '0, i2cIndex = '0;
	logic [15:0] spiData = '0, i2cData = '0, mem [2][64];
	logic [3:0]  i2cFuse = '0;
	logic        busy, spiDone, spiRespOk, i2cDone, i2cNack, wrStrobe, wrDomain, errFlag, wrStrobe2, flag2, rej2;
	logic [5:0]  wrIndex;
	logic [15:0] wrData;
	logic [31:0] spiResp, spiCap;
	logic [44:0] i2cCap;
	logic [22:0] lastW;
	int          mismatches = 0, total_checks = 0, nWr = 0, nWr2 = 0, nRej2 = 0, i2cCnt = 0;

	always #12.5 clk_sys = ~clk_sys;

	hfc_link_if link();
	hfc_link_if link2();
	hfc_host_end hfc_host_end_i (.link(link), .clk_sys(clk_sys), .reset(reset), .spiReq(spiReq),
		.spiDomain(spiDomain), .spiIndex(spiIndex), .spiWrite(spiWrite), .spiData(spiData), .i2cReq(i2cReq),
		.i2cFuse(i2cFuse), .i2cDomain(i2cDomain), .i2cIndex(i2cIndex), .i2cData(i2cData), .busy(busy),
		.spiDone(spiDone), .spiResp(spiResp), .spiRespOk(spiRespOk), .i2cDone(i2cDone), .i2cNack(i2cNack));
	hfc_device_end hfc_device_end_i (.link(link), .clk_sys(clk_sys), .reset(reset), .fuseAddr(FUSE),
		.deviceStatus(STAT), .wrStrobe(wrStrobe), .wrDomain(wrDomain), .wrIndex(wrIndex), .wrData(wrData),
		.communicationErrorFlag(errFlag), .frameReject());
	hfc_device_end hfc_device_end_i2 (.link(link2), .clk_sys(clk_sys), .reset(reset), .fuseAddr(FUSE),
		.deviceStatus(STAT), .wrStrobe(wrStrobe2), .wrDomain(), .wrIndex(), .wrData(),
		.communicationErrorFlag(flag2), .frameReject(rej2));
	hfc_link_chk hfc_link_chk_i (.clk_sys(clk_sys), .reset(reset), .csN(link.csN), .sclk(link.sclk),
		.mosi(link.mosi), .misoOeN(link.misoOeN), .devSdaOeN(link.devSdaOeN), .sclOeN(link.sclOeN),
		.sclLine(link.sclLine), .sdaLine(link.sdaLine));

	// Monitors of the write reports and of both wires.
	always @(posedge clk_sys) begin
		if (wrStrobe === 1'b1) begin
			nWr++;
			lastW = {wrDomain, wrIndex, wrData};
		end
		nWr2 += int'(wrStrobe2 === 1'b1);
		nRej2 += int'(rej2 === 1'b1);
	end
	always @(negedge link.sclk) if (link.csN === 1'b0) spiCap = {spiCap[30:0], link.mosi};
	always @(negedge link.sdaLine) if (link.sclLine === 1'b1) i2cCnt = 0;
	always @(posedge link.sclLine) begin
		if (i2cCnt < 45) i2cCap[44-i2cCnt] = link.sdaLine;
		i2cCnt++;
	end

	function automatic logic [7:0] crcCalc(input logic [31:0] m, input int n);
		logic [7:0] r;
		r = 8'hFF;
		for (int i = 31; i > 31 - n; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ m[i]) ? 8'h1D : 8'h00);
		end
		return r;
	endfunction : crcCalc

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task waitIdle;
		repeat (2) @(negedge clk_sys);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk_sys);
	endtask : waitIdle

	task spiRaw(input logic [31:0] w, output logic [31:0] r);
		@(negedge clk_sys) link2.csN = 1'b0;
		#30;
		for (int i = 31; i >= 0; i--) begin
			#15 link2.sclk = 1'b1;
			link2.mosi = w[i];
			#15 r[i] = link2.misoLine;
			link2.sclk = 1'b0;
		end
		#30 link2.csN = 1'b1;
		repeat (10) @(posedge clk_sys);
	endtask : spiRaw

	task i2cRun(input logic [3:0] f, input logic d, input logic ok);
		int w0;
		w0 = nWr;
		@(negedge clk_sys);
		{i2cFuse, i2cDomain, i2cIndex, i2cData, i2cReq} = {f, d, 6'h2A, 16'hBEEF, 1'b1};
		@(negedge clk_sys) i2cReq = 1'b0;
		waitIdle();
		check(i2cCap[44:37], {2'b01, f, d, 1'b0});
		check({i2cNack, 31'(nWr - w0)}, {!ok, 31'(ok)});
		if (ok) begin
			check({i2cCap[35:28], i2cCap[0]}, {8'h2A, 1'b0});
			check(i2cCap[8:1], crcCalc({2'b01, f, d, 1'b0, 8'h2A, 16'hBEEF}, 32));
			check(lastW, {d, 6'h2A, 16'hBEEF});
		end
		$display("Test two-wire domain %0d ok %0d done", d, ok);
	endtask : i2cRun

	initial begin
		#400000;
		mismatches++;
		$display("ERROR at %0t: run timed out", $time);
		end_of_test();
	end

	initial begin
		logic [31:0] r, w;
		logic [23:0] h;
		logic [15:0] prev, prevResp;
		logic [7:0]  ec;
		int          w0;
		{link2.csN, link2.sclk, link2.mosi, link2.sclOut, link2.sclOeN} = 5'b10001;
		{link2.hostSdaOut, link2.hostSdaOeN} = 2'b01;
		mem = '{default: '{default: 16'h0000}};
		repeat (8) @(negedge clk_sys);
		check({busy, link.csN, link.sclk, link.misoOeN, errFlag}, 5'b01010);
		reset = 1'b0;
		$display("Test reset done");
		for (int k = 0; k < 6; k++) begin
			w0 = nWr;
			h = {rows[k].d, rows[k].x, rows[k].w, rows[k].v};
			prev = mem[rows[k].d][rows[k].x];
			ec = (rows[k].c === 8'h00) ? crcCalc({h, 8'h00}, 24) : rows[k].c;
			@(negedge clk_sys);
			{spiDomain, spiIndex, spiWrite, spiData, spiReq} = {h, 1'b1};
			@(negedge clk_sys) spiReq = 1'b0;
			waitIdle();
			check(spiCap, {h, ec});
			check(nWr - w0, 32'(rows[k].w));
			if (rows[k].w) check(lastW, {rows[k].d, rows[k].x, rows[k].v});
			if (rows[k].w) mem[rows[k].d][rows[k].x] = rows[k].v;
			if (k > 0) check({spiResp[31:8], spiRespOk}, {1'b0, STAT, prevResp, 1'b1});
			if (k > 0) check(spiResp[7:0], crcCalc(spiResp, 24));
			prevResp = prev;
			$display("Test serial row %0d done", k);
		end
		i2cRun(FUSE, 1'b0, 1'b1);
		i2cRun(FUSE, 1'b1, 1'b1);
		i2cRun(~FUSE, 1'b0, 1'b0);
		h = {1'b0, 6'h05, 1'b1, 16'h1234};
		spiRaw({h, crcCalc({h, 8'h00}, 24) ^ 8'h01}, r);
		check(nRej2, 32'd1);
		check(nWr2, 32'd0);
		check(32'(flag2), 32'd1);
		h = {1'b0, 6'h05, 1'b0, 16'h0000};
		spiRaw({h, crcCalc({h, 8'h00}, 24)}, r);
		check(r, {1'b1, STAT, 16'h0000, crcCalc(r, 24)});
		check(nWr2, 32'd0);
		check(32'(flag2), 32'd0);
		h = {1'b0, 6'h05, 1'b1, 16'hABCD};
		w = {h, crcCalc({h, 8'h00}, 24)};
		spiRaw(w, r);
		check(nRej2, 32'd1);
		check(nWr2, 32'd1);
		$display("Test corrupt frame done");
		end_of_test();
	end
endmodule : host_frame_crc_and_i2c_addressing_test
